/* File: include/servo_io_map.svh */
// Purpose: Register offsets, field positions and timing figures
// Assumes: 32-bit AXI4-Lite data, byte addresses
// Notes: Definitions only
`ifndef SERVO_IO_MAP_SVH
`define SERVO_IO_MAP_SVH

// Register byte offsets
`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0C

// Field positions
`define CTRL_CCW_MASK_BIT 0
`define IRQ_W 4
`define IRQ_ALARM_BIT 0
`define IRQ_OVERTRAVEL_BIT 1
`define IRQ_SON_DROP_BIT 2
`define IRQ_READY_BIT 3

// Alarm codes above this need a power cycle
`define ALARM_CLR_MAX 4'h8
`define ALARM_CODE_W 4

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing: settle after enable, clock period, glitch filter
`define SON_SETTLE_NS 32'h02FA_F080
`define CLK_PERIOD_NS 32'h0000_0008
`define FILT_CYCLES 16'h0010

`endif

/* File: include/servo_io_pkg.sv */
// Purpose: Types shared by the discrete input control block
// Assumes: Field widths match servo_io_map.svh
// Notes: Status word is read in the low bits of the status register
package servo_io_pkg;

    // Status register layout, high bits first, low bits at the right
    typedef struct packed {
        logic [3:0] alarm_code;
        logic alarm_latched;
        logic cmd_ready;
        logic ccw_allowed;
        logic power_on;
        logic alarm_clear;
        logic ccw_enable;
        logic servo_enable;
    } drive_status_t;

    // Filtered discrete inputs
    typedef struct packed {
        logic alarm_clear;
        logic ccw_enable;
        logic servo_enable;
    } pin_set_t;

endpackage : servo_io_pkg

/* File: logic/input_filter.sv */
// Purpose: Synchronise one discrete input and reject glitches
// Assumes: Pin is asynchronous to aclk
// Notes: Output moves only after the input held steady FILT cycles
`timescale 1ns/10ps
`include "servo_io_map.svh"

module input_filter #(
    parameter logic [15:0] FILT = `FILT_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pin and filtered level
    input wire logic pin,
    output logic level
);

    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic [15:0] cnt_r;
    logic level_r;

    // Three-stage synchroniser; first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Stability counter; any disagreement restarts it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 16'h0000;
            level_r <= 1'b0;
        end else if (sync2_r != sync3_r || sync3_r == level_r) begin
            cnt_r <= 16'h0000;
        end else if (cnt_r == FILT - 16'h0001) begin
            level_r <= sync3_r;
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    assign level = level_r;

    // A short pulse on the pin never reaches the output
    a_glitch_reject: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(level_r) |-> $past(sync3_r) == level_r && $past(cnt_r) == FILT - 16'h0001)
        else $error("filtered level changed before the input was stable");

endmodule : input_filter

/* File: logic/servo_input_ctrl.sv */
// Purpose: Discrete input control of a servo drive power stage
// Assumes: Opto inputs high when on; AXI4-Lite master keeps protocol
// Notes: Register map and timing figures in servo_io_map.svh
// What this block does
// - Servo enable on lets the power stage run and commands be followed.
// - Servo enable off switches the power stage off and stops operation.
// - Servo enable off leaves the motor unpowered, coasting without holding torque.
// - Alarm clear on clears the latched alarm; off keeps it latched.
// - Alarms with fault code above 8 ignore alarm clear until power-up.
// - Counterclockwise enable input on allows counterclockwise rotation.
// - Counterclockwise enable input off prevents counterclockwise rotation.
// - During that overtravel, counterclockwise torque is held at zero.
// - Mask parameter set ignores the input and allows counterclockwise drive whenever the power stage is on.
`timescale 1ns/10ps
`include "servo_io_map.svh"

module servo_input_ctrl
    import servo_io_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES =
        (`SON_SETTLE_NS + `CLK_PERIOD_NS - 32'h0000_0001) / `CLK_PERIOD_NS,
    parameter logic [15:0] FILT = `FILT_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Discrete opto inputs, high when on
    input wire logic servo_enable_pin,
    input wire logic alarm_clear_pin,
    input wire logic ccw_enable_pin,
    // Fault report from the protection logic
    input wire logic fault_valid,
    input wire logic [`ALARM_CODE_W-1:0] fault_code,
    // Drive controls
    output logic power_stage_en,
    output logic cmd_ready,
    output logic ccw_torque_en,
    output logic alarm_latched,
    output logic [`ALARM_CODE_W-1:0] alarm_code,
    output logic irq,
    // AXI4-Lite write address and data
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    pin_set_t pins;
    pin_set_t raw;
    drive_status_t stat;
    logic power_r;
    logic cmd_ready_r;
    logic ccw_r;
    logic alarm_r;
    logic [`ALARM_CODE_W-1:0] code_r;
    logic [31:0] settle_cnt_r;
    logic ccw_mask_r;
    logic [`IRQ_W-1:0] irq_stat_r;
    logic [`IRQ_W-1:0] irq_stat_nxt;
    logic [`IRQ_W-1:0] irq_mask_r;
    logic [`IRQ_W-1:0] irq_evt;
    logic irq_r;
    logic son_d_r;
    logic block_d_r;
    logic ready_d_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [`ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_go;
    logic rd_go;
    logic ccw_block;

    // Decode shared by the write and read paths
    function automatic logic is_mapped(input logic [`ADDR_W-1:0] a);
        is_mapped = a == `OFS_CTRL || a == `OFS_STATUS ||
                    a == `OFS_IRQ_STAT || a == `OFS_IRQ_MASK;
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////
    // Input conditioning

    assign raw.servo_enable = servo_enable_pin;
    assign raw.ccw_enable = ccw_enable_pin;
    assign raw.alarm_clear = alarm_clear_pin;

    // One filter per discrete input
    generate
        for (genvar i = 0; i < $bits(pin_set_t); i++) begin : g_filt
            input_filter #(
                .FILT(FILT)
            ) u_filt (
                .aclk(aclk),
                .aresetn(aresetn),
                .pin(raw[i]),
                .level(pins[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Power stage and command readiness

    // Latched alarm also drops the stage, so a fault never drives on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_r <= 1'b0;
        end else begin
            power_r <= pins.servo_enable && !alarm_r;
        end
    end

    // Settle timer restarts each time the stage comes on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_cnt_r <= 32'h0000_0000;
            cmd_ready_r <= 1'b0;
        end else if (!power_r) begin
            settle_cnt_r <= 32'h0000_0000;
            cmd_ready_r <= 1'b0;
        end else if (settle_cnt_r < SETTLE_CYCLES - 1) begin
            settle_cnt_r <= settle_cnt_r + 32'h0000_0001;
            cmd_ready_r <= 1'b0;
        end else begin
            cmd_ready_r <= pins.servo_enable && !alarm_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alarm latch

    // New fault wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_r <= 1'b0;
            code_r <= 4'h0;
        end else if (fault_valid && !alarm_r) begin
            alarm_r <= 1'b1;
            code_r <= fault_code;
        end else if (fault_valid && fault_code > `ALARM_CLR_MAX) begin
            code_r <= fault_code;
        end else if (!fault_valid && pins.alarm_clear && code_r <= `ALARM_CLR_MAX) begin
            alarm_r <= 1'b0;
            code_r <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Counterclockwise torque gate

    assign ccw_block = !pins.ccw_enable && !ccw_mask_r;

    // Mask parameter overrides the limit switch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ccw_r <= 1'b0;
        end else begin
            ccw_r <= power_r && !ccw_block;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt status and output

    // Edge history; blocked is the idle level after reset, so no false overtravel edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            son_d_r <= 1'b0;
            block_d_r <= 1'b1;
            ready_d_r <= 1'b0;
        end else begin
            son_d_r <= pins.servo_enable;
            block_d_r <= ccw_block;
            ready_d_r <= cmd_ready_r;
        end
    end

    always_comb begin
        irq_evt = '0;
        irq_evt[`IRQ_ALARM_BIT] = fault_valid && !alarm_r;
        irq_evt[`IRQ_OVERTRAVEL_BIT] = ccw_block && !block_d_r;
        irq_evt[`IRQ_SON_DROP_BIT] = son_d_r && !pins.servo_enable;
        irq_evt[`IRQ_READY_BIT] = cmd_ready_r && !ready_d_r;
        irq_stat_nxt = irq_stat_r;
        if (rd_go && araddr == `OFS_IRQ_STAT) begin
            irq_stat_nxt = '0;
        end
        irq_stat_nxt = irq_stat_nxt | irq_evt;
    end

    // Set beats read-clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path

    assign wr_go = !awready_r && !wready_r && !bvalid_r;

    // Address and data accepted in any order, held until the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            aw_addr_r <= '0;
        end else if (awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_addr_r <= awaddr;
        end else if (bvalid_r && bready) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
        end else if (bvalid_r && bready) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= is_mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Only byte lane 0 holds writable bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ccw_mask_r <= 1'b0;
            irq_mask_r <= '0;
        end else if (wr_go && w_strb_r[0]) begin
            if (aw_addr_r == `OFS_CTRL) begin
                ccw_mask_r <= w_data_r[`CTRL_CCW_MASK_BIT];
            end
            if (aw_addr_r == `OFS_IRQ_MASK) begin
                irq_mask_r <= w_data_r[`IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path

    assign rd_go = arvalid && arready_r;

    assign stat = '{alarm_code: code_r, alarm_latched: alarm_r,
                    cmd_ready: cmd_ready_r, ccw_allowed: ccw_r,
                    power_on: power_r, alarm_clear: pins.alarm_clear,
                    ccw_enable: pins.ccw_enable,
                    servo_enable: pins.servo_enable};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= `RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (rd_go) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
            unique case (araddr)
                `OFS_CTRL: rdata_r <= 32'(ccw_mask_r);
                `OFS_STATUS: rdata_r <= 32'(stat);
                `OFS_IRQ_STAT: rdata_r <= 32'(irq_stat_r);
                `OFS_IRQ_MASK: rdata_r <= 32'(irq_mask_r);
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else if (rvalid_r && rready) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops

    assign power_stage_en = power_r;
    assign cmd_ready = cmd_ready_r;
    assign ccw_torque_en = ccw_r;
    assign alarm_latched = alarm_r;
    assign alarm_code = code_r;
    assign irq = irq_r;
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_son_drop;
        pins.servo_enable ##1 !pins.servo_enable;
    endsequence

    sequence s_stage_cut;
        !power_r ##1 (!power_r && !ccw_r);
    endsequence

    a_enable_runs: assert property (
        pins.servo_enable && !alarm_r |=> power_r)
        else $error("power stage off while enabled and alarm free");

    a_disable_stops: assert property (
        s_son_drop |=> s_stage_cut)
        else $error("power stage still on after enable dropped");

    a_coast_free: assert property (
        !power_r |-> !cmd_ready_r ##1 !ccw_r)
        else $error("torque or commands allowed while stage off");

    a_settle_wait: assert property (
        $rose(power_r) |-> !cmd_ready_r [*8])
        else $error("command ready too soon after enable");

    a_alarm_clear: assert property (
        alarm_r && pins.alarm_clear && code_r <= `ALARM_CLR_MAX && !fault_valid
        |=> !alarm_r)
        else $error("low-code alarm not cleared");

    a_alarm_kept: assert property (
        alarm_r && !pins.alarm_clear |=> alarm_r)
        else $error("alarm dropped without a clear");

    a_high_code: assert property (
        alarm_r && code_r > `ALARM_CLR_MAX |=> alarm_r && code_r > `ALARM_CLR_MAX)
        else $error("high-code alarm was cleared");

    a_ccw_allow: assert property (
        power_r && pins.ccw_enable |=> ccw_r)
        else $error("ccw torque blocked while input on");

    a_ccw_block: assert property (
        !pins.ccw_enable && !ccw_mask_r |=> !ccw_r)
        else $error("ccw torque not zero in overtravel");

    a_ccw_mask: assert property (
        power_r && ccw_mask_r |=> ccw_r)
        else $error("masked ccw input still blocked torque");

    a_irq_level: assert property (
        |(irq_stat_r & irq_mask_r) |=> irq_r)
        else $error("interrupt low with unmasked status set");

endmodule : servo_input_ctrl

/* File: sim/host_model.sv */
// Purpose: Host motion controller driving the isolated input pins
// Assumes: Pins high when on; one clock shared with the device
// Notes: Standstill is judged by how long the power stage has been off
`timescale 1ns/10ps

module host_model #(
    parameter int COAST = 8,
    parameter int SETTLE = 20
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Requests from the bench
    input wire logic en_req,
    input wire logic clr_req,
    input wire logic ccw_req,
    // Device feedback
    input wire logic power_stage_en,
    input wire logic cmd_ready,
    // Pins and motion gate
    output logic servo_enable_pin,
    output logic alarm_clear_pin,
    output logic ccw_enable_pin,
    output logic motion_go
);
    int stop_cnt;
    int settle_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Coast-down timer, a stand-in for a speed feedback
    always_ff @(posedge aclk) begin
        if (!aresetn || power_stage_en) begin
            stop_cnt <= 0;
        end else if (stop_cnt < COAST) begin
            stop_cnt <= stop_cnt + 1;
        end
    end

    // Enable rises only on a motor at rest, drops at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            servo_enable_pin <= 1'h0;
        end else begin
            servo_enable_pin <= en_req && (servo_enable_pin || stop_cnt == COAST);
        end
    end

    // Other pins follow requests, short pulses included
    always_ff @(posedge aclk) begin
        alarm_clear_pin <= aresetn && clr_req;
        ccw_enable_pin <= aresetn && ccw_req;
    end

    // Own settle count after enable
    always_ff @(posedge aclk) begin
        if (!servo_enable_pin) begin
            settle_cnt <= 0;
        end else if (settle_cnt < SETTLE) begin
            settle_cnt <= settle_cnt + 1;
        end
    end

    // Motion only once both gates are open
    assign motion_go = cmd_ready && settle_cnt >= SETTLE;
endmodule : host_model

/* File: sim/servo_input_ctrl_test.sv */
// Purpose: Self-checking bench of the discrete input control block
// Assumes: Short settle and filter counts set at the instance
// Notes: Output waits sample on the falling edge; bus responses are sampled on the rising edge
`timescale 1ns/10ps
`include "servo_io_map.svh"

module servo_input_ctrl_test;
    localparam int ST = 20;
    localparam int PW = 0;
    localparam int CR = 1;
    localparam int CC = 2;
    localparam int AL = 3;
    localparam int IQ = 4;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic en_req = 1'h0, clr_req = 1'h0, ccw_req = 1'h0, fault_valid = 1'h0;
    logic [3:0] fault_code = 4'h0;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic servo_enable_pin, alarm_clear_pin, ccw_enable_pin, motion_go;
    logic power_stage_en, cmd_ready, ccw_torque_en, alarm_latched, irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] alarm_code;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    wire [4:0] outs = {irq, alarm_latched, ccw_torque_en, cmd_ready, power_stage_en};
    int error_cnt = 0;
    int checked = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, device and host
    always #4 aclk = ~aclk;

    servo_input_ctrl #(.SETTLE_CYCLES(ST), .FILT(16'h0004)) servo_input_ctrl_inst (
        .aclk(aclk), .aresetn(aresetn), .servo_enable_pin(servo_enable_pin),
        .alarm_clear_pin(alarm_clear_pin), .ccw_enable_pin(ccw_enable_pin),
        .fault_valid(fault_valid), .fault_code(fault_code), .power_stage_en(power_stage_en),
        .cmd_ready(cmd_ready), .ccw_torque_en(ccw_torque_en), .alarm_latched(alarm_latched),
        .alarm_code(alarm_code), .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    host_model #(.COAST(8), .SETTLE(ST)) host_model_inst (
        .aclk(aclk), .aresetn(aresetn), .en_req(en_req), .clr_req(clr_req), .ccw_req(ccw_req),
        .power_stage_en(power_stage_en), .cmd_ready(cmd_ready),
        .servo_enable_pin(servo_enable_pin), .alarm_clear_pin(alarm_clear_pin),
        .ccw_enable_pin(ccw_enable_pin), .motion_go(motion_go));

    ////////////////////////////////////////////////////////////////////////////
    // Compares, counted; case equality so unknowns fail
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask : chk_bit

    // Bounded wait for an output level, then judged
    task automatic wait_out(input int i, input logic v, input int n);
        int k;
        k = 0;
        do begin
            @(negedge aclk);
            k++;
        end while (outs[i] !== v && k < n);
        chk_bit(outs[i], v);
    endtask : wait_out

    task automatic hold_out(input int i, input logic v, input int n);
        repeat (n) begin
            @(negedge aclk);
            chk_bit(outs[i], v);
        end
    endtask : hold_out

    task automatic reset_dut();
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
    endtask : reset_dut

    task automatic fault(input logic [3:0] c);
        @(posedge aclk);
        fault_code <= c;
        fault_valid <= 1'h1;
        @(posedge aclk);
        fault_valid <= 1'h0;
    endtask : fault

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw_done;
        bit w_done;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        aw_done = 0;
        w_done = 0;
        forever begin
            @(posedge aclk);
            if (!aw_done && awready) begin
                aw_done = 1;
                awvalid <= 1'h0;
            end
            if (!w_done && wready) begin
                w_done = 1;
                wvalid <= 1'h0;
            end
            if (bvalid) begin
                bready <= 1'h0;
                chk_word({30'h0000_0000, bresp}, {30'h0000_0000, er});
                break;
            end
        end
    endtask : wr

    // Read: data masked before compare
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
        bit ar_done;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        ar_done = 0;
        forever begin
            @(posedge aclk);
            if (!ar_done && arready) begin
                ar_done = 1;
                arvalid <= 1'h0;
            end
            if (rvalid) begin
                rready <= 1'h0;
                chk_word(rdata & m, e);
                chk_word({30'h0000_0000, rresp}, {30'h0000_0000, er});
                break;
            end
        end
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_regs();
        chk_bit(power_stage_en, 1'h0);
        rd(`OFS_STATUS, 32'hffff_ffff, 32'h0000_0000, `RESP_OKAY);
        rd(`OFS_CTRL, 32'hffff_ffff, 32'h0000_0000, `RESP_OKAY);
        rd(`OFS_IRQ_MASK, 32'hffff_ffff, 32'h0000_0000, `RESP_OKAY);
        rd(8'h10, 32'hffff_ffff, 32'h0000_0000, `RESP_SLVERR);
        wr(8'h10, 32'h0000_0001, `RESP_SLVERR);
        wr(`OFS_STATUS, 32'hffff_ffff, `RESP_OKAY);
        rd(`OFS_STATUS, 32'hffff_ffff, 32'h0000_0000, `RESP_OKAY);
        $display("test_regs done");
    endtask : test_regs

    task automatic test_enable();
        @(posedge aclk);
        en_req <= 1'h1;
        wait_out(PW, 1'h1, 60);
        chk_bit(motion_go, 1'h0);
        hold_out(CR, 1'h0, ST - 1);
        wait_out(CR, 1'h1, 4);
        chk_bit(motion_go, 1'h1);
        rd(`OFS_STATUS, 32'h0000_07ff, 32'h0000_0029, `RESP_OKAY);
        rd(`OFS_IRQ_STAT, 32'h0000_000f, 32'h0000_0008, `RESP_OKAY);
        $display("test_enable done");
    endtask : test_enable

    task automatic test_ccw();
        chk_bit(ccw_torque_en, 1'h0);
        @(posedge aclk);
        ccw_req <= 1'h1;
        repeat (2) @(posedge aclk);
        ccw_req <= 1'h0;
        hold_out(CC, 1'h0, 20);
        @(posedge aclk);
        ccw_req <= 1'h1;
        wait_out(CC, 1'h1, 40);
        @(posedge aclk);
        ccw_req <= 1'h0;
        wait_out(CC, 1'h0, 40);
        rd(`OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0002, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h0000_0001, `RESP_OKAY);
        wait_out(CC, 1'h1, 4);
        rd(`OFS_CTRL, 32'h0000_0001, 32'h0000_0001, `RESP_OKAY);
        $display("test_ccw done");
    endtask : test_ccw

    task automatic test_disable();
        wr(`OFS_IRQ_MASK, 32'h0000_0004, `RESP_OKAY);
        @(posedge aclk);
        en_req <= 1'h0;
        wait_out(PW, 1'h0, 40);
        wait_out(CR, 1'h0, 2);
        wait_out(CC, 1'h0, 2);
        wait_out(IQ, 1'h1, 4);
        rd(`OFS_IRQ_STAT, 32'h0000_0004, 32'h0000_0004, `RESP_OKAY);
        wait_out(IQ, 1'h0, 4);
        wr(`OFS_CTRL, 32'h0000_0000, `RESP_OKAY);
        $display("test_disable done");
    endtask : test_disable

    task automatic test_alarm();
        wr(`OFS_IRQ_MASK, 32'h0000_0000, `RESP_OKAY);
        fault(4'h9);
        wait_out(AL, 1'h1, 4);
        chk_word({28'h000_0000, alarm_code}, 32'h0000_0009);
        @(posedge aclk);
        clr_req <= 1'h1;
        hold_out(AL, 1'h1, 40);
        chk_bit(irq, 1'h0);
        rd(`OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001, `RESP_OKAY);
        @(posedge aclk);
        clr_req <= 1'h0;
        reset_dut();
        wait_out(AL, 1'h0, 2);
        wr(`OFS_IRQ_MASK, 32'h0000_0001, `RESP_OKAY);
        fault(4'h8);
        wait_out(IQ, 1'h1, 4);
        chk_word({28'h000_0000, alarm_code}, 32'h0000_0008);
        rd(`OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001, `RESP_OKAY);
        wait_out(IQ, 1'h0, 4);
        hold_out(AL, 1'h1, 30);
        @(posedge aclk);
        clr_req <= 1'h1;
        wait_out(AL, 1'h0, 40);
        chk_word({28'h000_0000, alarm_code}, 32'h0000_0000);
        $display("test_alarm done");
    endtask : test_alarm

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic finish_test();
        $display("Compares: %0d, mismatches: %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        reset_dut();
        test_regs();
        test_enable();
        test_ccw();
        test_disable();
        test_alarm();
        finish_test();
    end

    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule : servo_input_ctrl_test
